// ===== core/adsr_pkg.sv
// Package: register map, field positions, reset values and timing constants of the status/mode bank
package adsr_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam logic [5:0] IDENT_IDX = 6'h00;
	localparam logic [5:0] DEV_STATUS_IDX = 6'h01;
	localparam logic [5:0] OP_MODE_IDX = 6'h02;
	localparam logic [5:0] EVT_STATUS_IDX = 6'h20;
	localparam logic [5:0] EVT_CLEAR_IDX = 6'h21;
	localparam logic [5:0] EVT_ENABLE_IDX = 6'h22;
	// Arbitrary value for the fixed upper identification nibble
	localparam logic [3:0] IDENT_UPPER = 4'h7;
	localparam logic [3:0] CHANNEL_TOTAL = 4'h2;
	// Arbitrary value for the revision byte
	localparam logic [7:0] IDENT_REVISION = 8'h5A;
	localparam logic [15:0] DEV_STATUS_RESET = 16'h0500;
	localparam logic [15:0] OP_MODE_RESET = 16'h0510;
	localparam logic [15:0] OP_MODE_WMASK = 16'h3F1F;
	localparam int ST_LOCK = 15;
	localparam int ST_RESYNC = 14;
	localparam int ST_MAPCRC = 13;
	localparam int ST_CRCERR = 12;
	localparam int ST_CRCTYPE = 11;
	localparam int ST_RESET = 10;
	localparam int MD_REGCRC_EN = 13;
	localparam int MD_RXCRC_EN = 12;
	localparam int MD_RESET = 10;
	localparam int EVT_W = 6;
	localparam logic [1:0] SRC_LAGGING = 2'h0;
	localparam logic [1:0] SRC_OR = 2'h1;
	localparam int CLK_MHZ = 25;
	localparam int PULSE_NS = 200;
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] PULSE_CNT = 4'(PULSE_CYC);
endpackage

// ===== core/adsr_pulse.sv
// Fixed-width low pulse generator for the data-ready pin
module adsr_pulse
	import adsr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic fire_i,
	output logic busy_o
);
	typedef struct packed {
		logic [3:0] cnt;
	} adsr_pulse_state_type;
	adsr_pulse_state_type s_r;
	adsr_pulse_state_type s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (fire_i)
			s_nxt.cnt = PULSE_CNT;
		else if (s_r.cnt != 4'h0)
			s_nxt.cnt = s_r.cnt - 4'h1;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign busy_o = (s_r.cnt != 4'h0);

	pulse_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		fire_i |=> busy_o [*4]) else $error("ready pulse too short");
endmodule

// ===== core/adsr_regs.sv
// Identification, status and mode register bank with event interrupt and data-ready pin
module adsr_regs
	import adsr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	// Converter events
	input wire logic lock_i,
	input wire logic resync_i,
	input wire logic map_crc_change_i,
	input wire logic rx_crc_error_i,
	input wire logic chan_zero_new_data_i,
	input wire logic chan_one_new_data_i,
	input wire logic chan_zero_read_i,
	input wire logic chan_one_read_i,
	// Configuration to datapath
	output logic map_crc_en_o,
	output logic rx_crc_en_o,
	output logic timeout_en_o,
	output logic [1:0] word_size_select_o,
	// Data-ready pin and interrupt
	output logic ready_pin_o,
	output logic ready_pin_oe_o,
	output logic irq_o
);
	typedef struct packed {
		logic [15:0] mode;
		logic resync_seen_flag;
		logic map_flag;
		logic crcerr_flag;
		logic rst_flag;
		logic chan_zero_new_data;
		logic chan_one_new_data;
		logic [EVT_W-1:0] evt;
		logic [EVT_W-1:0] evt_en;
		logic pend_q;
		logic [15:0] rdata;
	} adsr_regs_state_type;
	adsr_regs_state_type s_r;
	adsr_regs_state_type s_nxt;

	logic [15:0] ident_v;
	logic [15:0] status_v;
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] evt_clr;
	logic pend;
	logic fire;
	logic busy;
	logic [1:0] src;

	assign ident_v = {IDENT_UPPER, CHANNEL_TOTAL, IDENT_REVISION};
	assign status_v = {lock_i, s_r.resync_seen_flag, s_r.map_flag, s_r.crcerr_flag,
		s_r.mode[ST_CRCTYPE], s_r.rst_flag, s_r.mode[9:8],
		6'h00, s_r.chan_one_new_data, s_r.chan_zero_new_data};
	assign evt_set = {resync_i, map_crc_change_i & s_r.mode[MD_REGCRC_EN],
		rx_crc_error_i & s_r.mode[MD_RXCRC_EN], chan_one_new_data_i, chan_zero_new_data_i, 1'b0};
	assign evt_clr = (wr_i && addr_i == EVT_CLEAR_IDX) ? wdata_i[EVT_W-1:0] : '0;
	assign src = s_r.mode[3:2];

	always_comb
	begin
		s_nxt = s_r;
		// Status flags: set beats clear in the same cycle
		if (resync_i)
			s_nxt.resync_seen_flag = 1'b1;
		else if (rd_i && addr_i == DEV_STATUS_IDX)
			s_nxt.resync_seen_flag = 1'b0;
		if (map_crc_change_i && s_r.mode[MD_REGCRC_EN])
			s_nxt.map_flag = 1'b1;
		else if (rd_i && addr_i == DEV_STATUS_IDX)
			s_nxt.map_flag = 1'b0;
		if (rx_crc_error_i && s_r.mode[MD_RXCRC_EN])
			s_nxt.crcerr_flag = 1'b1;
		else if (rd_i && addr_i == DEV_STATUS_IDX)
			s_nxt.crcerr_flag = 1'b0;
		if (chan_zero_new_data_i)
			s_nxt.chan_zero_new_data = 1'b1;
		else if (chan_zero_read_i)
			s_nxt.chan_zero_new_data = 1'b0;
		if (chan_one_new_data_i)
			s_nxt.chan_one_new_data = 1'b1;
		else if (chan_one_read_i)
			s_nxt.chan_one_new_data = 1'b0;
		if (wr_i && addr_i == OP_MODE_IDX)
		begin
			s_nxt.mode = wdata_i & OP_MODE_WMASK;
			if (!wdata_i[MD_RESET])
				s_nxt.rst_flag = 1'b0;
		end
		if (wr_i && addr_i == EVT_ENABLE_IDX)
			s_nxt.evt_en = wdata_i[EVT_W-1:0];
		s_nxt.evt = (s_r.evt & ~evt_clr) | evt_set;
		s_nxt.pend_q = pend;
		s_nxt.rdata = 16'h0000;
		if (rd_i)
		begin
			unique case (addr_i)
				IDENT_IDX: s_nxt.rdata = ident_v;
				DEV_STATUS_IDX: s_nxt.rdata = status_v;
				OP_MODE_IDX: s_nxt.rdata = {s_r.mode[15:11], s_r.rst_flag, s_r.mode[9:0]};
				EVT_STATUS_IDX: s_nxt.rdata = {10'h000, s_r.evt};
				EVT_ENABLE_IDX: s_nxt.rdata = {10'h000, s_r.evt_en};
				default: s_nxt.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_r <= '0;
			s_r.mode <= OP_MODE_RESET;
			s_r.rst_flag <= DEV_STATUS_RESET[ST_RESET];
		end
		else
			s_r <= s_nxt;
	end

	// Data-ready source selection
	always_comb
	begin
		pend = 1'b0;
		unique case (src)
			SRC_LAGGING: pend = s_r.chan_zero_new_data & s_r.chan_one_new_data;
			SRC_OR: pend = s_r.chan_zero_new_data | s_r.chan_one_new_data;
			default: pend = s_r.chan_zero_new_data | s_r.chan_one_new_data;
		endcase
	end
	assign fire = pend & ~s_r.pend_q;

	adsr_pulse u_pulse (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.fire_i(fire),
		.busy_o(busy)
	);

	always_comb
	begin
		if (s_r.mode[0])
			ready_pin_o = ~busy;
		else
			ready_pin_o = ~pend;
		ready_pin_oe_o = ~(s_r.mode[1] & ready_pin_o);
	end

	assign rdata_o = s_r.rdata;
	assign irq_o = |(s_r.evt & s_r.evt_en);
	assign map_crc_en_o = s_r.mode[MD_REGCRC_EN];
	assign rx_crc_en_o = s_r.mode[MD_RXCRC_EN];
	assign timeout_en_o = s_r.mode[4];
	assign word_size_select_o = s_r.mode[9:8];

	// Read-back of the identification and status words
	ident_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == IDENT_IDX |=> rdata_o[15:8] == {IDENT_UPPER, CHANNEL_TOTAL})
		else $error("bad identification");

	ident_rev_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == IDENT_IDX |=> rdata_o[7:0] == IDENT_REVISION)
		else $error("bad revision byte");

	mirror_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == DEV_STATUS_IDX |=> rdata_o[11] == $past(s_r.mode[11])
		&& rdata_o[9:8] == $past(s_r.mode[9:8])) else $error("status mirror wrong");

	reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == DEV_STATUS_IDX |=> rdata_o[7:2] == 6'h00)
		else $error("reserved status set");

	lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == DEV_STATUS_IDX |=> rdata_o[15] == $past(lock_i))
		else $error("lock bit wrong");

	resync_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == DEV_STATUS_IDX |=> rdata_o[14] == $past(s_r.resync_seen_flag))
		else $error("resync bit wrong");

	rst_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == DEV_STATUS_IDX |=> rdata_o[10] == $past(s_r.rst_flag))
		else $error("reset bit wrong");

	status_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == DEV_STATUS_IDX |=> rdata_o[1:0]
		== $past({s_r.chan_one_new_data, s_r.chan_zero_new_data})) else $error("data bits wrong");

	// Sticky status flags
	resync_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		resync_i |=> s_r.resync_seen_flag)
		else $error("resync flag lost");

	map_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		map_crc_change_i && s_r.mode[MD_REGCRC_EN] |=> s_r.map_flag)
		else $error("map checksum flag lost");

	map_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		map_crc_change_i && !s_r.mode[MD_REGCRC_EN] && !s_r.map_flag |=> !s_r.map_flag)
		else $error("map flag while disabled");

	crcerr_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_crc_error_i && s_r.mode[MD_RXCRC_EN] |=> s_r.crcerr_flag)
		else $error("checksum error flag lost");

	crcerr_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_crc_error_i && !s_r.mode[MD_RXCRC_EN] && !s_r.crcerr_flag && !rd_i |=> !s_r.crcerr_flag)
		else $error("checksum error while disabled");

	new_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
		chan_one_new_data_i |=> s_r.chan_one_new_data && s_r.evt[2])
		else $error("channel one data lost");

	chan_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		chan_zero_new_data_i |=> s_r.chan_zero_new_data && s_r.evt[1])
		else $error("channel zero data lost");

	// Mode register and its outputs
	mode_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == OP_MODE_IDX |=> s_r.mode == ($past(wdata_i) & OP_MODE_WMASK))
		else $error("mode write lost");

	mode_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == OP_MODE_IDX |=> rdata_o[15:11] == $past(s_r.mode[15:11])
		&& rdata_o[10] == $past(s_r.rst_flag)) else $error("mode read wrong");

	rst_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == OP_MODE_IDX && !wdata_i[MD_RESET] |=> !s_r.rst_flag)
		else $error("reset flag kept");

	rst_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == OP_MODE_IDX && wdata_i[MD_RESET] && s_r.rst_flag |=> s_r.rst_flag)
		else $error("reset flag dropped");

	status_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == DEV_STATUS_IDX |=> s_r.mode == $past(s_r.mode))
		else $error("status write acted");

	crc_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == OP_MODE_IDX |=> map_crc_en_o == $past(wdata_i[MD_REGCRC_EN])
		&& rx_crc_en_o == $past(wdata_i[MD_RXCRC_EN])) else $error("checksum enables wrong");

	word_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == OP_MODE_IDX |=> word_size_select_o == $past(wdata_i[9:8]))
		else $error("word length output wrong");

	// Data-ready pin
	ready_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!s_r.mode[0] && src == SRC_OR && s_r.chan_zero_new_data |-> !ready_pin_o && ready_pin_oe_o)
		else $error("ready pin not low");

	lagging_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!s_r.mode[0] && src == SRC_LAGGING && (s_r.chan_zero_new_data ^ s_r.chan_one_new_data)
		|-> ready_pin_o) else $error("lagging source fired early");

	leading_any_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!s_r.mode[0] && src[1] && s_r.chan_one_new_data |-> !ready_pin_o)
		else $error("leading source missed");

	idle_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_r.mode[1] && ready_pin_o |-> !ready_pin_oe_o)
		else $error("idle pin driven");

	idle_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!s_r.mode[1] |-> ready_pin_oe_o)
		else $error("pin not driven");

	pulse_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_r.mode[0] && fire && !wr_i |=> !ready_pin_o && ready_pin_oe_o)
		else $error("ready pulse missing");

	// Main scenarios
	cov_irq_c: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
	cov_lag_c: cover property (@(posedge clk_i) disable iff (rst_i) src == SRC_LAGGING && !ready_pin_o);
	cov_pulse_c: cover property (@(posedge clk_i) disable iff (rst_i) s_r.mode[0] && fire);
	cov_float_c: cover property (@(posedge clk_i) disable iff (rst_i) !ready_pin_oe_o);
	cov_rstclr_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(s_r.rst_flag));
endmodule

// ===== tb/adsr_host.sv
// Host model: drives the register port of the bank
module adsr_host
	import adsr_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Register port
	output logic [ADDR_W-1:0] addr_o,
	output logic [DATA_W-1:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [DATA_W-1:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		addr_o = '0;
		wdata_o = '0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask
endmodule

// ===== tb/tb.sv
// Testbench of the status/mode register bank
module tb;
	import adsr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic lock = 1'b0;
	logic [4:0] ev = '0;
	logic [1:0] rd_ack = '0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, d;
	logic wr, rd, map_en, rx_en, pin, pin_oe, irq;
	logic [1:0] wsel;
	logic tmo;
	int bad_count = 0;
	int tests_run = 0;
	initial
	begin
		forever #20 clk_i = ~clk_i;
	end
	adsr_host i_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
	adsr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .lock_i(lock), .resync_i(ev[4]), .map_crc_change_i(ev[3]), .rx_crc_error_i(ev[2]),
		.chan_zero_new_data_i(ev[0]), .chan_one_new_data_i(ev[1]), .chan_zero_read_i(rd_ack[0]),
		.chan_one_read_i(rd_ack[1]), .map_crc_en_o(map_en), .rx_crc_en_o(rx_en), .timeout_en_o(tmo),
		.word_size_select_o(wsel), .ready_pin_o(pin), .ready_pin_oe_o(pin_oe), .irq_o(irq));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pulse(input logic [4:0] v);
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= '0;
		#1;
	endtask
	task automatic t_reset();
		i_host.rd_reg(IDENT_IDX, d);
		chk({8'h00, d[15:8]}, {8'h00, IDENT_UPPER, CHANNEL_TOTAL});
		i_host.rd_reg(DEV_STATUS_IDX, d);
		chk(d, 16'h0500);
		i_host.rd_reg(OP_MODE_IDX, d);
		chk(d, 16'h0510);
		chk({13'h0, tmo, wsel}, 16'h0005);
		i_host.rd_reg(6'h3F, d);
		chk(d, 16'h0000);
		$display("reset test done");
	endtask
	task automatic t_events();
		lock <= 1'b1;
		pulse(5'h13);
		i_host.rd_reg(DEV_STATUS_IDX, d);
		chk(d, 16'hC503);
		i_host.wr_reg(DEV_STATUS_IDX, 16'h0000);
		i_host.rd_reg(DEV_STATUS_IDX, d);
		chk(d, 16'h8503);
		chk({15'h0, pin}, 16'h0000);
		chk({15'h0, pin_oe}, 16'h0001);
		$display("event test done");
	endtask
	task automatic t_mode();
		i_host.wr_reg(OP_MODE_IDX, 16'h3B03);
		i_host.rd_reg(OP_MODE_IDX, d);
		chk(d, 16'h3B03);
		chk({11'h0, tmo, map_en, rx_en, wsel}, 16'h000F);
		pulse(5'h0C);
		i_host.rd_reg(DEV_STATUS_IDX, d);
		chk(d, 16'hBB03);
		$display("mode test done");
	endtask
	// Pulse format with floating idle level; lagging source needs both channels
	task automatic t_pulse();
		@(posedge clk_i);
		rd_ack <= 2'b01;
		@(posedge clk_i);
		rd_ack <= 2'b00;
		pulse(5'h01);
		chk({14'h0, pin, pin_oe}, 16'h0002);
		@(posedge clk_i);
		#1 chk({14'h0, pin, pin_oe}, 16'h0001);
		repeat (5) @(posedge clk_i);
		#1 chk({14'h0, pin, pin_oe}, 16'h0002);
		$display("pulse test done");
	endtask
	task automatic t_irq();
		i_host.wr_reg(EVT_CLEAR_IDX, 16'h003F);
		i_host.wr_reg(EVT_ENABLE_IDX, 16'h0020);
		#1 chk({15'h0, irq}, 16'h0000);
		pulse(5'h10);
		chk({15'h0, irq}, 16'h0001);
		i_host.rd_reg(EVT_STATUS_IDX, d);
		chk(d, 16'h0020);
		i_host.rd_reg(EVT_ENABLE_IDX, d);
		chk(d, 16'h0020);
		i_host.wr_reg(EVT_CLEAR_IDX, 16'h0020);
		#1 chk({15'h0, irq}, 16'h0000);
		$display("interrupt test done");
	endtask
	task automatic t_rerst();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		i_host.rd_reg(DEV_STATUS_IDX, d);
		chk(d, 16'h8500);
		i_host.rd_reg(OP_MODE_IDX, d);
		chk(d, 16'h0510);
		chk({14'h0, pin, pin_oe}, 16'h0003);
		$display("second reset test done");
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_events();
		t_mode();
		t_pulse();
		t_irq();
		t_rerst();
		stop_test();
	end
	initial
	begin
		#200us;
		bad_count++;
		stop_test();
	end
endmodule
